// [core/sfp_device.sv]
// Flash device end: serial front end, status register and protection
// Contract
// - Serial modes 0 and 3 both work
// - Sample on rising, launch on falling edge
// - 4K sectors, 64K blocks, bounded address range
// - Bit 0 read-only busy flag
// - Latch clear blocks every modifying operation
// - Unlock instruction sets write-enable latch
// - Lock instruction or completion clears latch
// - Protect bits block writes in region
// - Whole erase only with protect bits zero
// - Lock plus low pin freezes status
// - Otherwise status writes are accepted
// - Protect and lock bits default zero
// - Quad enable turns protect pin to data
// - Master avoids quad enable with tied pins
// - Status byte layout fixed, reset zero
// - Frames MSB first, chip enable closes
// - Modifying frames need whole-byte pulse count
`timescale 1ns/1ps
`include "sfp_params.svh"
module sfp_device #(
    parameter int          DENSITY_MBIT = 4,
    parameter logic [31:0] PROG_CYC     = `SFP_PROG_CYCLES,
    parameter logic [31:0] ERASE_CYC    = `SFP_ERASE_CYCLES,
    parameter logic [31:0] STATUS_WRITE_CMD_CYC     = `SFP_STATUS_WRITE_CMD_CYCLES
)
(
    // Serial link
    sfp_link_if.dev              link,
    // System clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    // Array operation requests and status view
    output logic                 op_start_q,
    output sfp_pkg::sfp_op_t     op_kind_q,
    output logic [23:0]          op_addr_q,
    output logic [7:0]           status_q
);
    import sfp_pkg::*;

    localparam int          NBLK      = DENSITY_MBIT * 2;
    localparam logic [23:0] LAST_ADDR = (DENSITY_MBIT == 2) ? `SFP_LAST_ADDR_2M : `SFP_LAST_ADDR_4M;

    generate
        if (DENSITY_MBIT != 2 && DENSITY_MBIT != 4)
        begin : g_chk
            $error("sfp_device density must be 2 or 4 Mbit");
        end
    endgenerate

    // region chosen by the protect bits, at block granularity
    function automatic logic prot_hit(input logic [3:0] bp, input logic [23:0] addr);
        int blk;
        int cnt;
        blk = int'(addr[23:16]);
        cnt = 0;
        prot_hit = 1'b0;
        if (bp >= 4'h1 && bp <= 4'h6)
        begin
            cnt = 1 << (int'(bp) - 1);
            prot_hit = blk >= NBLK - cnt;
        end
        else if (bp == 4'h7 || bp == 4'h8)
        begin
            prot_hit = 1'b1;
        end
        else if (bp >= 4'h9 && bp <= 4'hE)
        begin
            cnt = 1 << (14 - int'(bp));
            prot_hit = blk < cnt;
        end
    endfunction

    // ---------------- Link domain (serial clock) ----------------
    logic        frame_rst;
    logic        live_q;
    logic        live_d;
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic [7:0]  opc_q;
    logic [7:0]  opc_d;
    logic [31:0] arg_q;
    logic [31:0] arg_d;
    logic        busy_lk;
    logic        so_d;
    logic        so_q;
    logic        oe_d;
    logic        oe_q;
    logic [7:0]  snap;
    logic        rd_act;

    // Raised chip enable ends the frame without needing a clock edge
    assign frame_rst = link.ce_n | ~rst_n;

    sfp_sync #(
        .WIDTH   (1),
        .RST_VAL (1'b0)
    ) u_busy_sync (
        .clk   (link.sck),
        .rst_n (rst_n),
        .d     (status_q[`SFP_STAT_BUSY]),
        .q     (busy_lk)
    );

    // shift opcode then arguments, MSB first
    always_comb
    begin
        live_d = 1'b1;
        cnt_d  = cnt_q;
        opc_d  = opc_q;
        arg_d  = arg_q;
        if (!live_q)
        begin
            cnt_d = 12'h001;
            opc_d = {7'h00, link.mosi};
            arg_d = 32'h0000_0000;
        end
        else
        begin
            if (cnt_q != 12'hFFF)
                cnt_d = cnt_q + 12'h001;
            if (cnt_q < 12'(`SFP_BITS_OPCODE))
                opc_d = {opc_q[6:0], link.mosi};
            else if (cnt_q < 12'(`SFP_BITS_PROGRAM))
                arg_d = {arg_q[30:0], link.mosi};
        end
    end

    // frame restarts from chip enable, not from clock level
    always_ff @(posedge link.sck or posedge frame_rst)
    begin
        if (frame_rst)
            live_q <= 1'b0;
        else
            live_q <= live_d;
    end

    // input captured on rising edges; held after the frame
    always_ff @(posedge link.sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 12'h000;
            opc_q <= 8'h00;
            arg_q <= 32'h0000_0000;
        end
        else
        begin
            cnt_q <= cnt_d;
            opc_q <= opc_d;
            arg_q <= arg_d;
        end
    end

    // status byte streams out repeatedly, busy refreshed live
    assign snap   = {status_q[7:1], busy_lk};
    assign rd_act = live_q && opc_q == `SFP_CMD_STATUS_READ && cnt_q >= 12'(`SFP_BITS_OPCODE);
    always_comb
    begin
        so_d = so_q;
        oe_d = oe_q;
        if (rd_act)
        begin
            so_d = snap[~cnt_q[2:0]];
            oe_d = 1'b1;
        end
    end

    always_ff @(negedge link.sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            so_q <= so_d;
            oe_q <= oe_d;
        end
    end

    assign link.so_out = so_q;
    assign link.so_oe  = oe_q;

    // ---------------- System domain ----------------
    logic        ce_s;
    logic        wp_s;
    logic        ce_prev_q;
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;
    logic [7:0]  stat_d;
    logic        start_d;
    sfp_op_t     kind_d;
    logic [23:0] addr_d;
    logic        exec;
    logic        write_enable_latch;
    logic        busy;
    logic        locked;
    logic        word_ok;
    logic [23:0] tgt;
    logic [3:0]  bp;

    sfp_sync #(
        .WIDTH   (2),
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .d     ({link.ce_n, link.wp_n}),
        .q     ({ce_s, wp_s})
    );

    assign exec    = ce_s & ~ce_prev_q;
    assign write_enable_latch     = status_q[`SFP_STAT_WEL];
    assign busy    = status_q[`SFP_STAT_BUSY];
    assign bp      = status_q[`SFP_STAT_BP_HI:`SFP_STAT_BP_LO];
    // with quad enable the pin is a data line, no protect role
    // lock bit plus low pin freezes status
    assign locked  = status_q[`SFP_STAT_LOCK] & ~wp_s & ~status_q[`SFP_STAT_QE];
    // modifying frames must hold whole bytes
    assign word_ok = cnt_q[2:0] == 3'h0;
    assign tgt     = (cnt_q == 12'(`SFP_BITS_ERASE)) ? arg_q[23:0] : arg_q[31:8];

    // busy flag set at execution, cleared at end
    always_comb
    begin
        stat_d     = status_q;
        busy_cnt_d = busy_cnt_q;
        start_d    = 1'b0;
        kind_d     = op_kind_q;
        addr_d     = op_addr_q;
        if (busy_cnt_q != 32'h0000_0000)
        begin
            busy_cnt_d = busy_cnt_q - 32'h0000_0001;
            if (busy_cnt_q == 32'h0000_0001)
            begin
                // latch cleared once the write completes
                stat_d[`SFP_STAT_BUSY] = 1'b0;
                stat_d[`SFP_STAT_WEL]  = 1'b0;
            end
        end
        // nothing modifying runs without the latch or while busy
        if (exec && !busy && word_ok)
        begin
            case (opc_q)
                `SFP_CMD_WRITE_UNLOCK:
                    if (cnt_q == 12'(`SFP_BITS_OPCODE))
                        stat_d[`SFP_STAT_WEL] = 1'b1;
                `SFP_CMD_WRITE_LOCK:
                    if (cnt_q == 12'(`SFP_BITS_OPCODE))
                        stat_d[`SFP_STAT_WEL] = 1'b0;
                `SFP_CMD_STATUS_WRITE:
                    if (cnt_q == 12'(`SFP_BITS_STATUS_WR) && write_enable_latch && !locked)
                    begin
                        // lock, quad and protect bits updated
                        stat_d[7:2]            = arg_q[7:2];
                        stat_d[`SFP_STAT_BUSY] = 1'b1;
                        busy_cnt_d             = STATUS_WRITE_CMD_CYC;
                        start_d                = 1'b1;
                        kind_d                 = SFP_OP_STATUS_WRITE_CMD;
                    end
                `SFP_CMD_PAGE_PROGRAM:
                    if (cnt_q >= 12'(`SFP_BITS_PROGRAM) && write_enable_latch && tgt <= LAST_ADDR && !prot_hit(bp, tgt))
                    begin
                        stat_d[`SFP_STAT_BUSY] = 1'b1;
                        busy_cnt_d             = PROG_CYC;
                        start_d                = 1'b1;
                        kind_d                 = SFP_OP_PROG;
                        addr_d                 = tgt;
                    end
                `SFP_CMD_SECTOR_ERASE,
                `SFP_CMD_BLOCK_ERASE:
                    if (cnt_q == 12'(`SFP_BITS_ERASE) && write_enable_latch && tgt <= LAST_ADDR && !prot_hit(bp, tgt))
                    begin
                        stat_d[`SFP_STAT_BUSY] = 1'b1;
                        busy_cnt_d             = ERASE_CYC;
                        start_d                = 1'b1;
                        kind_d                 = (opc_q == `SFP_CMD_SECTOR_ERASE) ? SFP_OP_SECTOR : SFP_OP_BLOCK;
                        addr_d                 = (opc_q == `SFP_CMD_SECTOR_ERASE) ? {tgt[23:12], 12'h000}
                                                                                  : {tgt[23:16], 16'h0000};
                    end
                // whole erase only when protect bits are zero
                `SFP_CMD_ARRAY_ERASE:
                    if (cnt_q == 12'(`SFP_BITS_OPCODE) && write_enable_latch && bp == 4'h0)
                    begin
                        stat_d[`SFP_STAT_BUSY] = 1'b1;
                        busy_cnt_d             = ERASE_CYC;
                        start_d                = 1'b1;
                        kind_d                 = SFP_OP_CHIP;
                        addr_d                 = 24'h00_0000;
                    end
                default:
                    stat_d = status_q;
            endcase
        end
    end

    // status register, reset to all zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_q   <= `SFP_STAT_RESET;
            busy_cnt_q <= 32'h0000_0000;
            ce_prev_q  <= 1'b1;
            op_start_q <= 1'b0;
            op_kind_q  <= SFP_OP_NONE;
            op_addr_q  <= 24'h00_0000;
        end
        else
        begin
            status_q   <= stat_d;
            busy_cnt_q <= busy_cnt_d;
            ce_prev_q  <= ce_s;
            op_start_q <= start_d;
            op_kind_q  <= kind_d;
            op_addr_q  <= addr_d;
        end
    end
endmodule

// [common/sfp_params.svh]
// Constants of the serial flash status and protection block
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH
// Status register layout
`define SFP_STAT_BUSY      0
`define SFP_STAT_WEL       1
`define SFP_STAT_BP_LO     2
`define SFP_STAT_BP_HI     5
`define SFP_STAT_QE        6
`define SFP_STAT_LOCK      7
`define SFP_STAT_RESET     8'h00
// Instruction codes (encodings chosen for this block)
`define SFP_CMD_WRITE_UNLOCK 8'h06
`define SFP_CMD_WRITE_LOCK   8'h04
`define SFP_CMD_STATUS_READ  8'h05
`define SFP_CMD_STATUS_WRITE 8'h01
`define SFP_CMD_PAGE_PROGRAM 8'h02
`define SFP_CMD_SECTOR_ERASE 8'h20
`define SFP_CMD_BLOCK_ERASE  8'hD8
`define SFP_CMD_ARRAY_ERASE  8'hC7
// Frame lengths in serial clock pulses
`define SFP_BITS_OPCODE    8
`define SFP_BITS_STATUS_WR 16
`define SFP_BITS_ERASE     32
`define SFP_BITS_PROGRAM   40
// Address map
`define SFP_SECTOR_BYTES   4096
`define SFP_BLOCK_SECTORS  16
`define SFP_LAST_ADDR_2M   24'h03_FFFF
`define SFP_LAST_ADDR_4M   24'h07_FFFF
// Busy durations in sys_clk cycles (operation timing is not modelled)
`define SFP_PROG_CYCLES    32'h0000_0100
`define SFP_ERASE_CYCLES   32'h0000_0400
`define SFP_STATUS_WRITE_CMD_CYCLES    32'h0000_0080
`endif

// [common/sfp_pkg.sv]
// Types shared by both ends of the serial flash link
package sfp_pkg;
    // Modifying operations started on the array
    typedef enum logic [2:0] {
        SFP_OP_NONE   = 3'h0,
        SFP_OP_STATUS_WRITE_CMD   = 3'h1,
        SFP_OP_PROG   = 3'h2,
        SFP_OP_SECTOR = 3'h3,
        SFP_OP_BLOCK  = 3'h4,
        SFP_OP_CHIP   = 3'h5
    } sfp_op_t;
    // Master frame sequencer, Gray along idle-low-high-end
    typedef enum logic [1:0] {
        SFP_HS_IDLE = 2'b00,
        SFP_HS_LO   = 2'b01,
        SFP_HS_HI   = 2'b11,
        SFP_HS_END  = 2'b10
    } sfp_hstate_t;
endpackage

// [common/sfp_link_if.sv]
// Serial link between the master and the flash device
`timescale 1ns/1ps
interface sfp_link_if;
    logic sck;
    logic ce_n;
    logic mosi;
    logic wp_n;
    logic hold_n;
    logic so_out;
    logic so_oe;
    logic miso;
    // Pulled up when the device does not drive its output
    assign miso = so_oe ? so_out : 1'b1;
    modport dev
    (
        input  sck,
        input  ce_n,
        input  mosi,
        input  wp_n,
        input  hold_n,
        output so_out,
        output so_oe
    );
    modport host
    (
        output sck,
        output ce_n,
        output mosi,
        output wp_n,
        output hold_n,
        input  miso
    );
endinterface

// [core/sfp_sync.sv]
// Two-flop level synchroniser
`timescale 1ns/1ps
module sfp_sync #(
    parameter int WIDTH    = 1,
    parameter bit RST_VAL  = 1'b0
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;
    generate
        if (WIDTH < 1)
        begin : g_chk
            $error("sfp_sync width must be positive");
        end
    endgenerate
    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= {WIDTH{RST_VAL}};
            q      <= {WIDTH{RST_VAL}};
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// [core/sfp_host.sv]
// Master end: runs one serial frame per request
`timescale 1ns/1ps
`include "sfp_params.svh"
module sfp_host #(
    parameter bit CPOL      = 1'b0,
    parameter int HALF_CYC  = 4
)
(
    // Serial link
    sfp_link_if.host             link,
    // System clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    // Frame request
    input  wire logic            cmd_valid,
    input  wire logic [7:0]      cmd_opcode,
    input  wire logic [31:0]     cmd_arg,
    input  wire logic [2:0]      cmd_tx_bytes,
    input  wire logic [2:0]      cmd_rx_bytes,
    input  wire logic            wp_level,
    input  wire logic            hold_level,
    // Frame answer
    output logic                 cmd_ready_q,
    output logic                 done_q,
    output logic [7:0]           rx_data_q
);
    import sfp_pkg::*;

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    generate
        if (HALF_CYC < 4 || HALF_CYC > 256)
        begin : g_chk
            $error("sfp_host half period must be 4 to 256 cycles");
        end
    endgenerate

    sfp_hstate_t st_q;
    sfp_hstate_t st_d;
    logic [7:0]  div_q;
    logic [7:0]  div_d;
    logic [6:0]  bits_q;
    logic [6:0]  bits_d;
    logic [39:0] tx_q;
    logic [39:0] tx_d;
    logic        sck_q;
    logic        sck_d;
    logic        ce_n_q;
    logic        ce_n_d;
    logic        mosi_q;
    logic        mosi_d;
    logic        wp_q;
    logic        hold_q;
    logic        ready_d;
    logic        done_d;
    logic [7:0]  rx_d;
    logic        miso_s;
    logic        tick;

    sfp_sync #(
        .WIDTH   (1),
        .RST_VAL (1'b1)
    ) u_miso_sync (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .d     (link.miso),
        .q     (miso_s)
    );

    assign tick = div_q == HALF_LAST;

    // Frame sequencer: clock low, high, then chip enable release
    always_comb
    begin
        st_d    = st_q;
        div_d   = tick ? 8'h00 : div_q + 8'h01;
        bits_d  = bits_q;
        tx_d    = tx_q;
        sck_d   = sck_q;
        ce_n_d  = ce_n_q;
        mosi_d  = mosi_q;
        ready_d = 1'b0;
        done_d  = 1'b0;
        rx_d    = rx_data_q;
        case (st_q)
            SFP_HS_IDLE:
            begin
                sck_d   = CPOL;
                ready_d = 1'b1;
                div_d   = 8'h00;
                if (cmd_valid && cmd_ready_q)
                begin
                    st_d    = SFP_HS_LO;
                    ce_n_d  = 1'b0;
                    sck_d   = 1'b0;
                    ready_d = 1'b0;
                    tx_d    = {cmd_opcode, cmd_arg << (6'd8 * (6'd4 - 6'(cmd_tx_bytes)))};
                    mosi_d  = cmd_opcode[7];
                    bits_d  = 7'(7'd8 * (7'd1 + 7'(cmd_tx_bytes) + 7'(cmd_rx_bytes)));
                end
            end
            SFP_HS_LO:
                if (tick)
                begin
                    st_d   = SFP_HS_HI;
                    sck_d  = 1'b1;
                    rx_d   = {rx_data_q[6:0], miso_s};
                    bits_d = bits_q - 7'd1;
                end
            SFP_HS_HI:
                if (tick)
                begin
                    if (bits_q == 7'd0)
                    begin
                        // clock returns to its idle level
                        st_d  = SFP_HS_END;
                        sck_d = CPOL;
                    end
                    else
                    begin
                        st_d   = SFP_HS_LO;
                        sck_d  = 1'b0;
                        tx_d   = tx_q << 1;
                        mosi_d = tx_q[38];
                    end
                end
            SFP_HS_END:
                if (tick)
                begin
                    // chip enable high after last bit, then a gap
                    if (!ce_n_q)
                        ce_n_d = 1'b1;
                    else
                    begin
                        st_d   = SFP_HS_IDLE;
                        done_d = 1'b1;
                        mosi_d = 1'b0;
                    end
                end
            default:
                st_d = SFP_HS_IDLE;
        endcase
    end

    // Registers of the sequencer and pins
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q        <= SFP_HS_IDLE;
            div_q       <= 8'h00;
            bits_q      <= 7'd0;
            tx_q        <= 40'h00_0000_0000;
            sck_q       <= CPOL;
            ce_n_q      <= 1'b1;
            mosi_q      <= 1'b0;
            wp_q        <= 1'b1;
            hold_q      <= 1'b1;
            cmd_ready_q <= 1'b0;
            done_q      <= 1'b0;
            rx_data_q   <= 8'h00;
        end
        else
        begin
            st_q        <= st_d;
            div_q       <= div_d;
            bits_q      <= bits_d;
            tx_q        <= tx_d;
            sck_q       <= sck_d;
            ce_n_q      <= ce_n_d;
            mosi_q      <= mosi_d;
            wp_q        <= wp_level;
            hold_q      <= hold_level;
            cmd_ready_q <= ready_d;
            done_q      <= done_d;
            rx_data_q   <= rx_d;
        end
    end

    assign link.sck    = sck_q;
    assign link.ce_n   = ce_n_q;
    assign link.mosi   = mosi_q;
    assign link.wp_n   = wp_q;
    assign link.hold_n = hold_q;
endmodule

// [verif/sfp_link_asserts.sv]
// Timing checks on the serial link between master and flash device
`timescale 1ns/1ps
module sfp_link_asserts #(
    parameter bit CPOL = 1'b0
)
(
    // System clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Link signals
    input  wire logic sck,
    input  wire logic ce_n,
    input  wire logic mosi,
    input  wire logic so_out,
    input  wire logic so_oe
);
    logic       sck_q;
    logic [7:0] rise_q;
    logic [7:0] rise_d;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Count rising serial clock edges within a frame
    always_comb
    begin
        rise_d = rise_q;
        if (ce_n)
            rise_d = 8'h00;
        else if (sck && !sck_q && rise_q != 8'hFF)
            rise_d = rise_q + 8'h01;
    end
    // Register the edge count and the previous clock level
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rise_q <= 8'h00;
            sck_q  <= CPOL;
        end
        else
        begin
            rise_q <= rise_d;
            sck_q  <= sck;
        end
    end
    chk_clk_idle_level: assert property (ce_n |-> sck == CPOL)
        else $error("serial clock not at idle level");
    chk_clk_high_half: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("serial clock high half wrong");
    chk_out_on_fall: assert property (!ce_n && !$past(ce_n) && $changed(so_out) |-> $fell(sck))
        else $error("device output moved off a falling edge");
    chk_in_while_low: assert property (!ce_n && !$past(ce_n) && $changed(mosi) |-> !sck)
        else $error("master data moved while clock high");
    chk_out_off_idle: assert property (so_oe |-> !ce_n)
        else $error("device drives output while deselected");
    chk_out_after_opcode: assert property ($rose(so_oe) |-> !sck && rise_d == 8'h08)
        else $error("device output enabled at wrong bit");
    chk_frame_whole_bytes: assert property ($rose(ce_n) |-> rise_q[2:0] == 3'h0 && sck == CPOL)
        else $error("frame closed mid byte");
    chk_deselect_gap: assert property ($rose(ce_n) |-> ce_n [*4])
        else $error("chip enable high time too short");
endmodule

// [verif/spi_flash_status_protect_tb_top.sv]
// Self-checking bench for the serial flash status and protection link
`timescale 1ns/1ps
`include "sfp_params.svh"
module spi_flash_status_protect_tb_top;
    import sfp_pkg::*;
    logic             sys_clk;
    logic             rst_n;
    logic             valid [2];
    logic [7:0]       opc [2];
    logic [31:0]      arg [2];
    logic [2:0]       txb [2];
    logic [2:0]       rxb [2];
    logic             wpl [2];
    wire logic        ready [2];
    wire logic        done [2];
    wire logic [7:0]  rxd [2];
    wire logic        start [2];
    wire sfp_op_t     kind [2];
    wire logic [23:0] addr [2];
    wire logic [7:0]  stat [2];
    int               err_total;
    int               check_count;
    int               starts = 0;
    // Mode 0 pair with the link checker, mode 3 pair beside it
    for (genvar g = 0; g < 2; g++)
    begin : pair
        sfp_link_if link_if ();
        sfp_host #(.CPOL(g == 1), .HALF_CYC(4)) sfp_host_inst (.link(link_if.host), .sys_clk(sys_clk),
            .rst_n(rst_n), .cmd_valid(valid[g]), .cmd_opcode(opc[g]), .cmd_arg(arg[g]), .cmd_tx_bytes(txb[g]),
            .cmd_rx_bytes(rxb[g]), .wp_level(wpl[g]), .hold_level(rst_n), .cmd_ready_q(ready[g]),
            .done_q(done[g]), .rx_data_q(rxd[g]));
        sfp_device #(.PROG_CYC(32'h0000_0040), .ERASE_CYC(32'h0000_0040),
            .STATUS_WRITE_CMD_CYC(32'h0000_0200)) sfp_device_inst (.link(link_if.dev), .sys_clk(sys_clk), .rst_n(rst_n),
            .op_start_q(start[g]), .op_kind_q(kind[g]), .op_addr_q(addr[g]), .status_q(stat[g]));
        if (g == 0)
        begin : chk
            sfp_link_asserts sfp_link_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n),
                .sck(link_if.sck), .ce_n(link_if.ce_n), .mosi(link_if.mosi), .so_out(link_if.so_out),
                .so_oe(link_if.so_oe));
        end
    end
    // Clock at 50 MHz
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Count operations the mode 0 device accepted
    always @(posedge sys_clk)
        if (start[0] === 1'b1)
            starts++;
    // Compare one observed value with its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Print counts and verdict, then stop
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Run one frame on pair i and let the device act on it
    task automatic frame(input int i, input logic [7:0] op, input logic [31:0] a, input logic [2:0] tx,
                         input logic [2:0] rx);
        int n;
        n = 0;
        opc[i] <= op;
        arg[i] <= a;
        txb[i] <= tx;
        rxb[i] <= rx;
        valid[i] <= 1'b1;
        @(posedge sys_clk);
        valid[i] <= 1'b0;
        do @(posedge sys_clk); while (done[i] !== 1'b1 && ++n < 2000);
        if (n >= 2000)
        begin
            err_total++;
            end_of_test();
        end
        repeat (5) @(posedge sys_clk);
    endtask
    // Unlock writes, then send one modifying frame
    task automatic op(input int i, input logic [7:0] code, input logic [31:0] a, input logic [2:0] tx);
        frame(i, `SFP_CMD_WRITE_UNLOCK, 32'h0000_0000, 3'h0, 3'h0);
        frame(i, code, a, tx, 3'h0);
    endtask
    // Write the status byte, then read it back at once over the link
    task automatic wr_status(input logic [7:0] v);
        op(0, `SFP_CMD_STATUS_WRITE, {24'h00_0000, v}, 3'h1);
        frame(0, `SFP_CMD_STATUS_READ, 32'h0000_0000, 3'h0, 3'h1);
    endtask
    // Wait, bounded, until the busy flag drops
    task automatic idle();
        int n;
        n = 0;
        while (stat[0][0] !== 1'b0 && ++n < 3000)
            @(posedge sys_clk);
        if (n >= 3000)
        begin
            err_total++;
            end_of_test();
        end
    endtask
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        err_total = 0;
        check_count = 0;
        valid = '{default: 1'b0};
        opc = '{default: 8'h00};
        arg = '{default: 32'h0000_0000};
        txb = '{default: 3'h0};
        rxb = '{default: 3'h0};
        wpl = '{default: 1'b1};
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check(stat[0], 8'h00);
        check(ready[0], 8'h01);
        frame(0, `SFP_CMD_STATUS_WRITE, 32'h0000_003C, 3'h1, 3'h0);
        check(stat[0], 8'h00);
        frame(0, `SFP_CMD_WRITE_UNLOCK, 32'h0000_0000, 3'h0, 3'h0);
        frame(0, `SFP_CMD_STATUS_READ, 32'h0000_0000, 3'h0, 3'h1);
        check(rxd[0], 8'h02);
        frame(0, `SFP_CMD_WRITE_LOCK, 32'h0000_0000, 3'h0, 3'h0);
        check(stat[0], 8'h00);
        // Lock and top block protection, read back while busy
        wr_status(8'h84);
        check(rxd[0], 8'h87);
        check(kind[0], SFP_OP_STATUS_WRITE_CMD);
        idle();
        check(stat[0], 8'h84);
        // Protect pin low freezes the status byte
        wpl[0] <= 1'b0;
        wr_status(8'h00);
        check(rxd[0] & 8'hFD, 8'h84);
        op(0, `SFP_CMD_ARRAY_ERASE, 32'h0000_0000, 3'h0);
        check(starts, 1);
        op(0, `SFP_CMD_PAGE_PROGRAM, 32'h0700_00A5, 3'h4);
        check(starts, 1);
        op(0, `SFP_CMD_PAGE_PROGRAM, 32'h0123_45A5, 3'h4);
        check(addr[0], 24'h01_2345);
        check(kind[0], SFP_OP_PROG);
        idle();
        wpl[0] <= 1'b1;
        wr_status(8'h00);
        check(rxd[0], 8'h03);
        idle();
        check(stat[0], 8'h00);
        // Erase addresses are aligned and bounded
        op(0, `SFP_CMD_SECTOR_ERASE, 32'h0007_1234, 3'h3);
        check(addr[0], 24'h07_1000);
        idle();
        op(0, `SFP_CMD_BLOCK_ERASE, 32'h0005_6789, 3'h3);
        check(addr[0], 24'h05_0000);
        idle();
        op(0, `SFP_CMD_SECTOR_ERASE, 32'h0008_0000, 3'h3);
        check(starts, 5);
        frame(0, `SFP_CMD_WRITE_LOCK, 32'h0000_0000, 3'h0, 3'h0);
        op(0, `SFP_CMD_ARRAY_ERASE, 32'h0000_0000, 3'h0);
        check(kind[0], SFP_OP_CHIP);
        idle();
        // quad enable only with driven pins; protect pin inert
        wr_status(8'hC0);
        idle();
        wpl[0] <= 1'b0;
        wr_status(8'h00);
        check(rxd[0], 8'h03);
        idle();
        // Mode 3 master reaches its device
        frame(1, `SFP_CMD_WRITE_UNLOCK, 32'h0000_0000, 3'h0, 3'h0);
        frame(1, `SFP_CMD_STATUS_READ, 32'h0000_0000, 3'h0, 3'h2);
        check(rxd[1], 8'h02);
        end_of_test();
    end
endmodule
